// *** hw/lldi_pkg.sv ***
// Constants, types and mode decoding for the DRAM init and mode-set block
package lldi_pkg;
  localparam int ADDR_W = 19;
  localparam int BANKS = 8;
  localparam int CLK_MHZ = 250;
  localparam int PWRUP_WAIT_US = 200;
  localparam int PWRUP_WAIT_CYCLES = PWRUP_WAIT_US * CLK_MHZ;
  localparam logic [3:0] SETTLE_LINK_CYCLES = 4'h6;
  localparam logic [10:0] DLL_LOCK_CYCLES = 11'h400;
  localparam logic [10:0] INIT_IDLE_COUNT = 11'h400;
  localparam logic [2:0] MIN_MODE_SETS = 3'h3;
  localparam logic [2:0] WR_RD_GAP = 3'h3;
  localparam logic CTRL_EN_RESET = 1'b1;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MODE = 8'h04;
  localparam logic [7:0] REG_TIMING = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_ERR = 8'h10;
  localparam int CTRL_EN = 0;
  localparam int CTRL_RESTART = 1;
  // Mode field positions on the address pins
  localparam int M_CFG = 0;
  localparam int M_BL = 3;
  localparam int M_MUX = 5;
  localparam int M_DLL = 7;
  localparam int M_IMP = 8;
  localparam int M_ODT = 9;
  // Error flag positions
  localparam int E_EARLY = 0;
  localparam int E_SETTLE = 1;
  localparam int E_UPPER = 2;
  localparam int E_RSV_CFG = 3;
  localparam int E_RSV_BL = 4;
  localparam int E_BL8 = 5;
  localparam int E_ROW = 6;
  localparam int E_TURN = 7;
  localparam int E_DLL = 8;
  localparam int E_BUSY = 9;
  localparam int E_ACCESS = 10;
  localparam int ERR_W = 11;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    CMD_IDLE, CMD_MODE_SET, CMD_REFRESH, CMD_READ, CMD_WRITE
  } lldi_cmd_e;

  typedef enum logic [4:0] {
    ST_PWRUP = 5'h01,
    ST_MRS = 5'h02,
    ST_INIT = 5'h04,
    ST_READY = 5'h08,
    ST_SPARE = 5'h10
  } lldi_state_e;

  typedef struct packed {
    logic ck;
    logic sel_n;
    logic wr_n;
    logic ref_n;
    logic [2:0] bank;
    logic [ADDR_W-1:0] addr;
  } lldi_pins_s;

  typedef struct packed {
    logic valid;
    lldi_cmd_e kind;
    logic [2:0] bank;
    logic [ADDR_W-1:0] addr;
  } lldi_cmd_s;

  typedef struct packed {
    lldi_pins_s meta;
    lldi_pins_s sync;
    logic ck_prev;
    lldi_pins_s hold;
    lldi_cmd_s cmd;
  } lldi_rx_s;

  typedef struct packed {
    logic on_die_termination;
    logic drive_impedance_select;
    logic dll_en;
    logic address_mux_select;
    logic [1:0] burst_len;
    logic [2:0] cfg;
    logic [3:0] row_cycle_time;
    logic [3:0] read_latency_cycles;
    logic [3:0] write_latency_cycles;
  } lldi_mode_s;

  function automatic lldi_mode_s lldi_mode_fn(input logic [9:0] a);
    lldi_mode_s m;
    m.on_die_termination = a[M_ODT];
    m.drive_impedance_select = a[M_IMP];
    m.dll_en = a[M_DLL];
    m.address_mux_select = a[M_MUX];
    m.burst_len = a[M_BL+1:M_BL];
    m.cfg = a[M_CFG+2:M_CFG];
    case (a[M_CFG+2:M_CFG])
      3'h0, 3'h1: m.row_cycle_time = 4'h4;
      3'h2: m.row_cycle_time = 4'h6;
      3'h3: m.row_cycle_time = 4'h8;
      3'h4: m.row_cycle_time = 4'h3;
      3'h5: m.row_cycle_time = 4'h5;
      default: m.row_cycle_time = 4'h0;
    endcase
    m.read_latency_cycles = m.row_cycle_time
      + {3'h0, a[M_MUX]};
    m.write_latency_cycles = m.read_latency_cycles + 4'h1;
    return m;
  endfunction

  localparam lldi_mode_s MODE_RESET = lldi_mode_fn(10'h000);

  typedef struct packed {
    logic ctrl_en;
    lldi_state_e init_st;
    logic [15:0] pwr_cnt;
    logic [2:0] ms_run;
    logic prev_ms;
    logic [BANKS-1:0] banks;
    logic [10:0] idle_cnt;
    lldi_mode_s mode;
    logic mux_half2;
    logic [9:0] ax;
    logic [3:0] settle;
    logic [BANKS-1:0][3:0] row_cnt;
    logic [2:0] wr_gap;
    logic [2:0] wr_bank;
    logic [10:0] dll_cnt;
    logic [ERR_W-1:0] err;
    logic aw_ok;
    logic [7:0] awaddr;
    logic w_ok;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } lldi_core_s;
endpackage

// *** hw/lldi_link_rx.sv ***
// Command pin sampler: synchronises pins and decodes one command per rising edge
`timescale 1ns/10ps
module lldi_link_rx
  import lldi_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // Command pins
  input wire lldi_pins_s pins_in,
  // Decoded command, one-cycle valid
  output lldi_cmd_s cmd_out
);
  lldi_rx_s st;
  lldi_rx_s next_st;

  always_comb begin
    next_st = st;
    next_st.meta = pins_in;
    next_st.sync = st.meta;
    next_st.ck_prev = st.sync.ck;
    next_st.cmd.valid = 1'b0;
    // Pins change just after the rising edge, so take them mid-period
    if (!st.sync.ck && st.ck_prev) begin
      next_st.hold = st.sync;
    end
    if (st.sync.ck && !st.ck_prev) begin
      next_st.cmd.valid = 1'b1;
      next_st.cmd.bank = st.hold.bank;
      next_st.cmd.addr = st.hold.addr;
      if (st.hold.sel_n) begin
        next_st.cmd.kind = CMD_IDLE;
      end else begin
        case ({st.hold.wr_n, st.hold.ref_n})
          2'b00: next_st.cmd.kind = CMD_MODE_SET;
          2'b10: next_st.cmd.kind = CMD_REFRESH;
          2'b11: next_st.cmd.kind = CMD_READ;
          default: next_st.cmd.kind = CMD_WRITE;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      st <= '0;
      st.hold.sel_n <= 1'b1;
      st.cmd.kind <= CMD_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign cmd_out = st.cmd;
endmodule

// *** hw/lldi_core.sv ***
// DRAM power-up tracking, mode register and AXI4-Lite register slave
`timescale 1ns/10ps
module lldi_core
  import lldi_pkg::*;
#(
  parameter int PWRUP_WAIT = PWRUP_WAIT_CYCLES
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // Command and address pins
  input wire lldi_pins_s link_in,
  // AXI4-Lite write address and data
  input wire logic axi_awvalid_in,
  output logic axi_awready_out,
  input wire logic [7:0] axi_awaddr_in,
  input wire logic axi_wvalid_in,
  output logic axi_wready_out,
  input wire logic [31:0] axi_wdata_in,
  input wire logic [3:0] axi_wstrb_in,
  // AXI4-Lite write response
  output logic axi_bvalid_out,
  input wire logic axi_bready_in,
  output logic [1:0] axi_bresp_out,
  // AXI4-Lite read
  input wire logic axi_arvalid_in,
  output logic axi_arready_out,
  input wire logic [7:0] axi_araddr_in,
  output logic axi_rvalid_out,
  input wire logic axi_rready_in,
  output logic [31:0] axi_rdata_out,
  output logic [1:0] axi_rresp_out,
  // Device state
  output lldi_mode_s mode_out,
  output logic init_ready_out
);
  lldi_core_s st;
  lldi_core_s next_st;
  lldi_cmd_s cmd;
  logic [BANKS-1:0] bank_busy;
  logic [ERR_W-1:0] err_set;
  logic [ERR_W-1:0] err_clr;
  logic [31:0] bmask;
  logic [9:0] new_mode;
  logic upd;
  logic burst_ms;
  logic dll_locked;
  lldi_mode_s nm;

  lldi_link_rx u_rx (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .pins_in(link_in),
    .cmd_out(cmd)
  );

  genvar b;
  generate
    for (b = 0; b < BANKS; b++) begin : g_bank
      assign bank_busy[b] = (st.row_cnt[b] != 4'h0);
    end
  endgenerate

  assign dll_locked = st.mode.dll_en && (st.dll_cnt == 11'h000);

  always_comb begin
    next_st = st;
    err_set = '0;
    err_clr = '0;
    new_mode = 10'h000;
    upd = 1'b0;
    burst_ms = 1'b0;
    bmask = {{8{st.wstrb[3]}}, {8{st.wstrb[2]}},
             {8{st.wstrb[1]}}, {8{st.wstrb[0]}}};
    nm = st.mode;
    // Power-up wait is counted on the core clock
    if (st.init_st == ST_PWRUP) begin
      if (st.pwr_cnt == 16'(PWRUP_WAIT)) begin
        next_st.init_st = ST_MRS;
      end else begin
        next_st.pwr_cnt = st.pwr_cnt + 16'h1;
      end
    end
    if (cmd.valid && st.ctrl_en) begin
      if (st.settle != 4'h0) next_st.settle = st.settle - 4'h1;
      if (st.wr_gap != 3'h0) next_st.wr_gap = st.wr_gap - 3'h1;
      if (st.dll_cnt != 11'h000) next_st.dll_cnt = st.dll_cnt - 11'h001;
      for (int i = 0; i < BANKS; i++) begin
        if (bank_busy[i]) next_st.row_cnt[i] = st.row_cnt[i] - 4'h1;
      end
      // Back-to-back mode-sets in ST_MRS skip the settle time
      burst_ms = st.prev_ms && cmd.kind == CMD_MODE_SET
        && st.init_st == ST_MRS;
      if (cmd.kind != CMD_IDLE && st.settle != 4'h0 && !burst_ms
          && !st.mux_half2) begin
        err_set[E_SETTLE] = 1'b1;
      end
      next_st.prev_ms = 1'b0;
      if (st.mux_half2) begin
        // Second half: A9 to M7, A4 to M2, A3 to M1, A8 unused
        next_st.mux_half2 = 1'b0;
        new_mode = {st.ax[9], st.ax[8], cmd.addr[9], 1'b0, st.ax[5],
                    st.ax[4], st.ax[3], cmd.addr[4], cmd.addr[3],
                    st.ax[0]};
        upd = 1'b1;
        if (cmd.addr[18:10] != 9'h000) err_set[E_UPPER] = 1'b1;
      end else begin
        case (cmd.kind)
          CMD_MODE_SET: begin
            next_st.prev_ms = 1'b1;
            next_st.settle = SETTLE_LINK_CYCLES;
            if (st.ms_run != 3'h7) next_st.ms_run = st.ms_run + 3'h1;
            if (st.init_st == ST_PWRUP) err_set[E_EARLY] = 1'b1;
            if (|bank_busy) err_set[E_BUSY] = 1'b1;
            if (st.mode.address_mux_select) begin
              if (cmd.addr[18:10] != 9'h000) err_set[E_UPPER] = 1'b1;
              next_st.ax = cmd.addr[9:0];
              next_st.mux_half2 = 1'b1;
            end else begin
              if (cmd.addr[17:10] != 8'h00) err_set[E_UPPER] = 1'b1;
              new_mode = cmd.addr[9:0] & 10'h3BF;
              upd = 1'b1;
            end
          end
          CMD_REFRESH: begin
            next_st.banks[cmd.bank] = 1'b1;
            if (bank_busy[cmd.bank]) err_set[E_ROW] = 1'b1;
            next_st.row_cnt[cmd.bank] = st.mode.row_cycle_time - 4'h1;
          end
          CMD_READ, CMD_WRITE: begin
            if (st.init_st != ST_READY) err_set[E_ACCESS] = 1'b1;
            if (bank_busy[cmd.bank]) err_set[E_ROW] = 1'b1;
            next_st.row_cnt[cmd.bank] = st.mode.row_cycle_time - 4'h1;
            if (cmd.kind == CMD_WRITE) begin
              next_st.wr_bank = cmd.bank;
              next_st.wr_gap = (st.mode.cfg == 3'h4) ? WR_RD_GAP
                                                    : 3'h0;
            end else begin
              if (st.wr_gap != 3'h0 && st.wr_bank == cmd.bank) begin
                err_set[E_TURN] = 1'b1;
              end
              if (st.dll_cnt != 11'h000) err_set[E_DLL] = 1'b1;
            end
          end
          default: begin
            if (st.init_st == ST_INIT && st.settle == 4'h0
                && st.idle_cnt != INIT_IDLE_COUNT) begin
              next_st.idle_cnt = st.idle_cnt + 11'h001;
            end
          end
        endcase
      end
      if (upd) begin
        nm = lldi_mode_fn(new_mode);
        if (new_mode[2:1] == 2'h3) err_set[E_RSV_CFG] = 1'b1;
        if (new_mode[4:3] == 2'h3) err_set[E_RSV_BL] = 1'b1;
        if (new_mode[4:3] == 2'h2
            && (new_mode[2:1] == 2'h0 || new_mode[2:0] == 3'h4)) begin
          err_set[E_BL8] = 1'b1;
        end
        // Enabling the loop restarts lock; dropping it is a loop reset
        if (nm.dll_en && !st.mode.dll_en) begin
          next_st.dll_cnt = DLL_LOCK_CYCLES;
        end
        if (!nm.dll_en) next_st.dll_cnt = 11'h000;
        next_st.mode = nm;
      end
      if (st.init_st == ST_MRS && cmd.kind != CMD_MODE_SET) begin
        if (st.ms_run >= MIN_MODE_SETS) next_st.init_st = ST_INIT;
        next_st.ms_run = 3'h0;
      end
    end
    if (st.init_st == ST_INIT && st.idle_cnt == INIT_IDLE_COUNT
        && &st.banks) begin
      next_st.init_st = ST_READY;
    end
    // Write channel: address and data taken in either order
    if (axi_awvalid_in && st.awready) begin
      next_st.aw_ok = 1'b1;
      next_st.awaddr = axi_awaddr_in;
    end
    if (axi_wvalid_in && st.wready) begin
      next_st.w_ok = 1'b1;
      next_st.wdata = axi_wdata_in;
      next_st.wstrb = axi_wstrb_in;
    end
    if (st.bvalid && axi_bready_in) next_st.bvalid = 1'b0;
    if (st.aw_ok && st.w_ok && !st.bvalid) begin
      next_st.aw_ok = 1'b0;
      next_st.w_ok = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      case ({st.awaddr[7:2], 2'b00})
        REG_CTRL: begin
          if (st.wstrb[0]) begin
            next_st.ctrl_en = st.wdata[CTRL_EN];
            if (st.wdata[CTRL_RESTART]) begin
              next_st.init_st = ST_PWRUP;
              next_st.pwr_cnt = 16'h0000;
              next_st.ms_run = 3'h0;
              next_st.banks = '0;
              next_st.idle_cnt = 11'h000;
            end
          end
        end
        REG_ERR: err_clr = st.wdata[ERR_W-1:0] & bmask[ERR_W-1:0];
        REG_MODE, REG_TIMING, REG_STATUS: ;
        default: next_st.bresp = RESP_SLVERR;
      endcase
    end
    // A flag raised in the clearing cycle survives
    next_st.err = (st.err & ~err_clr) | err_set;
    if (st.rvalid && axi_rready_in) next_st.rvalid = 1'b0;
    if (axi_arvalid_in && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      case ({axi_araddr_in[7:2], 2'b00})
        REG_CTRL: next_st.rdata = {31'h0, st.ctrl_en};
        REG_MODE: next_st.rdata = {22'h0, st.mode.on_die_termination,
          st.mode.drive_impedance_select, st.mode.dll_en, 1'b0,
          st.mode.address_mux_select, st.mode.burst_len, st.mode.cfg};
        REG_TIMING: next_st.rdata = {12'h0,
          st.mode.write_latency_cycles, 4'h0,
          st.mode.read_latency_cycles, 4'h0, st.mode.row_cycle_time};
        REG_STATUS: next_st.rdata = {7'h0, dll_locked, st.idle_cnt,
          st.banks, st.init_st};
        REG_ERR: next_st.rdata = {21'h0, st.err};
        default: begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = RESP_SLVERR;
        end
      endcase
    end
    next_st.awready = !next_st.aw_ok && !next_st.bvalid;
    next_st.wready = !next_st.w_ok && !next_st.bvalid;
    next_st.arready = !next_st.rvalid;
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      st <= '0;
      st.ctrl_en <= CTRL_EN_RESET;
      st.init_st <= ST_PWRUP;
      st.mode <= MODE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign axi_awready_out = st.awready;
  assign axi_wready_out = st.wready;
  assign axi_bvalid_out = st.bvalid;
  assign axi_bresp_out = st.bresp;
  assign axi_arready_out = st.arready;
  assign axi_rvalid_out = st.rvalid;
  assign axi_rdata_out = st.rdata;
  assign axi_rresp_out = st.rresp;
  assign mode_out = st.mode;
  // One-hot state: the ready bit is itself a flop, so no decode on the pin
  assign init_ready_out = st.init_st[3];
endmodule

// *** dv/lldi_core_assertions.sv ***
// Port-level checks on the init and mode-set block
`timescale 1ns/10ps
module lldi_core_checker
  import lldi_pkg::*;
#(
  parameter int PWRUP_WAIT = PWRUP_WAIT_CYCLES
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // Pins and read channel
  input wire lldi_pins_s link_in,
  input wire logic axi_rvalid_out,
  input wire logic axi_rready_in,
  // Device state
  input wire lldi_mode_s mode_out,
  input wire logic init_ready_out
);
  logic ck_q;
  logic ms_pin;
  logic [6:0] since_ms;
  logic [10:0] ck_cnt;
  assign ms_pin = ~(link_in.sel_n | link_in.wr_n | link_in.ref_n);
  // Counters saturate so a long idle stretch never wraps to look recent
  always_ff @(posedge core_clk_in) begin
    ck_q <= link_in.ck;
    if (!nrst_in || ms_pin) begin
      since_ms <= nrst_in ? 7'h00 : 7'h7F;
      ck_cnt <= 11'h000;
    end else begin
      if (since_ms != 7'h7F) since_ms <= since_ms + 7'h01;
      if (link_in.ck && !ck_q && ck_cnt != 11'h7FF)
        ck_cnt <= ck_cnt + 11'h001;
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  cfg_timing_a: assert property (
    mode_out.row_cycle_time == (mode_out.cfg < 3'h2 ? 4'h4 :
    mode_out.cfg == 3'h2 ? 4'h6 : mode_out.cfg == 3'h3 ? 4'h8 :
    mode_out.cfg == 3'h4 ? 4'h3 : mode_out.cfg == 3'h5 ? 4'h5 : 4'h0))
    else $error("row cycle does not match configuration");
  mux_latency_a: assert property (
    mode_out.read_latency_cycles ==
    mode_out.row_cycle_time + {3'h0, mode_out.address_mux_select})
    else $error("read latency wrong for address mode");
  write_latency_a: assert property (
    mode_out.write_latency_cycles == mode_out.read_latency_cycles + 4'h1)
    else $error("write latency is not read latency plus one");
  reserved_cfg_a: assert property (
    mode_out.cfg[2:1] == 2'h3 |-> mode_out.read_latency_cycles ==
    {3'h0, mode_out.address_mux_select})
    else $error("reserved configuration gives a latency");
  mode_cause_a: assert property (
    $changed(mode_out) |-> since_ms < 7'h50)
    else $error("mode changed without a mode-set on the pins");
  ready_count_a: assert property (
    $rose(init_ready_out) |-> ck_cnt >= 11'h400)
    else $error("ready before enough command clocks");
  reset_default_a: assert property (
    $rose(nrst_in) |-> mode_out == MODE_RESET && !init_ready_out)
    else $error("mode or ready not at default after reset");
  rvalid_hold_a: assert property (
    axi_rvalid_out && !axi_rready_in |=> axi_rvalid_out)
    else $error("read response dropped before it was taken");
endmodule
bind lldi_core lldi_core_checker #(.PWRUP_WAIT(PWRUP_WAIT)) i_core_chk (
  .core_clk_in(core_clk_in), .nrst_in(nrst_in), .link_in(link_in),
  .axi_rvalid_out(axi_rvalid_out), .axi_rready_in(axi_rready_in),
  .mode_out(mode_out), .init_ready_out(init_ready_out));

// *** dv/lldi_ctrl_model.sv ***
// Memory controller model driving the command pins
`timescale 1ns/10ps
module lldi_ctrl_model
  import lldi_pkg::*;
(
  // Command pins
  output lldi_pins_s pins_out
);
  logic ck = 1'b0;
  lldi_pins_s p = '{1'b0, 1'b1, 1'b1, 1'b1, 3'h0, 19'h00000};
  // Command clock runs freely once applied
  always #62.5 ck = ~ck;
  always_comb begin
    pins_out = p;
    pins_out.ck = ck;
  end
  // One command per rising edge, held for the whole period
  task automatic cmd(input logic [2:0] code, input logic [2:0] bank,
                     input logic [18:0] addr);
    @(posedge ck);
    #1;
    {p.sel_n, p.wr_n, p.ref_n} = code;
    p.bank = bank;
    p.addr = addr;
  endtask
  // Address is a don't-care while idle, so it toggles to expose stale use
  task automatic idle(input int n);
    repeat (n) cmd(3'h7, ~p.bank, ~p.addr);
  endtask
endmodule

// *** dv/lowlat_dram_init_and_mode_set_tb_top.sv ***
// Self-checking bench for the init and mode-set block
`timescale 1ns/10ps
module lowlat_dram_init_and_mode_set_tb_top
  import lldi_pkg::*;
;
  typedef struct packed {
    logic [9:0] addr;
    logic [31:0] timing;
    logic [31:0] err;
  } lldi_row_s;
  localparam logic [2:0] C_MS = 3'h0;
  localparam logic [2:0] C_WR = 3'h1;
  localparam logic [2:0] C_REF = 3'h2;
  localparam logic [2:0] C_RD = 3'h3;
  localparam logic [2:0] C_NOP = 3'h7;
  localparam lldi_row_s ROWS [14] = '{
    '{10'h000, 32'h50404, 32'h0}, '{10'h001, 32'h50404, 32'h0},
    '{10'h002, 32'h70606, 32'h0}, '{10'h003, 32'h90808, 32'h0},
    '{10'h004, 32'h40303, 32'h0}, '{10'h005, 32'h60505, 32'h0},
    '{10'h006, 32'h10000, 32'h8}, '{10'h007, 32'h10000, 32'h8},
    '{10'h012, 32'h70606, 32'h0}, '{10'h010, 32'h50404, 32'h20},
    '{10'h014, 32'h40303, 32'h20}, '{10'h01B, 32'h90808, 32'h10},
    '{10'h380, 32'h50404, 32'h0}, '{10'h04A, 32'h70606, 32'h0}};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, init_ready;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  lldi_mode_s mode;
  lldi_pins_s link;
  int miscompares = 0;
  int tests_run = 0;
  always #2 clk = ~clk;
  lldi_ctrl_model i_ctrl (.pins_out(link));
  lldi_core #(.PWRUP_WAIT(200)) i_dut (
    .core_clk_in(clk), .nrst_in(nrst), .link_in(link),
    .axi_awvalid_in(awvalid), .axi_awready_out(awready),
    .axi_awaddr_in(awaddr), .axi_wvalid_in(wvalid),
    .axi_wready_out(wready), .axi_wdata_in(wdata), .axi_wstrb_in(wstrb),
    .axi_bvalid_out(bvalid), .axi_bready_in(bready),
    .axi_bresp_out(bresp), .axi_arvalid_in(arvalid),
    .axi_arready_out(arready), .axi_araddr_in(araddr),
    .axi_rvalid_out(rvalid), .axi_rready_in(rready),
    .axi_rdata_out(rdata), .axi_rresp_out(rresp),
    .mode_out(mode), .init_ready_out(init_ready));
  task automatic tally_and_finish();
    if (miscompares == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_up();
    miscompares++;
    tally_and_finish();
  endtask
  function automatic logic [31:0] tim(input lldi_mode_s m);
    return {12'h0, m.write_latency_cycles, 4'h0, m.read_latency_cycles,
            4'h0, m.row_cycle_time};
  endfunction
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready) && n < 200);
    r = bresp;
    bready <= 1'b0;
    if (n >= 200) give_up();
  endtask
  // Ready is raised only after the response shows, to exercise its hold
  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && !rready) rready <= 1'b1;
    end while (!(rvalid && rready) && n < 200);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 200) give_up();
  endtask
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    chk("ready", {31'h0, init_ready}, 32'h0);
    chk("timing", tim(mode), 32'h50404);
    axr(REG_STATUS, d, r);
    chk("state", d & 32'h1F, 32'h1);
    i_ctrl.cmd(C_MS, 3'h0, 19'h0);
    i_ctrl.idle(2);
    axr(REG_ERR, d, r);
    chk("early", d & 32'h1, 32'h1);
    axw(REG_ERR, 32'h7FF, r);
    i_ctrl.idle(8);
    i_ctrl.cmd(C_MS, 3'h0, 19'h0);
    i_ctrl.cmd(C_MS, 3'h0, 19'h0);
    i_ctrl.cmd(C_MS, 3'h0, 19'h0008A);
    i_ctrl.idle(8);
    axr(REG_STATUS, d, r);
    chk("state", d & 32'h1F, 32'h4);
    for (int b = 0; b < 8; b++) i_ctrl.cmd(C_REF, 3'(7 - b), 19'h0);
    chk("ready", {31'h0, init_ready}, 32'h0);
    i_ctrl.idle(1030);
    for (int n = 0; n < 100 && init_ready !== 1'b1; n++) @(posedge clk);
    if (init_ready !== 1'b1) give_up();
    axr(REG_STATUS, d, r);
    chk("status", d & 32'h0100_1FFF, 32'h0100_1FE8);
    foreach (ROWS[i]) begin
      i_ctrl.cmd(C_MS, 3'h0, {9'h0, ROWS[i].addr});
      i_ctrl.idle(8);
      chk("timing", tim(mode), ROWS[i].timing);
      axr(REG_MODE, d, r);
      chk("mode", d, {22'h0, ROWS[i].addr & 10'h3BF});
      axr(REG_ERR, d, r);
      chk("err", d, ROWS[i].err);
      axw(REG_ERR, 32'h7FF, r);
    end
    i_ctrl.cmd(C_MS, 3'h0, 19'h2);
    i_ctrl.cmd(C_REF, 3'h0, 19'h0);
    i_ctrl.idle(2);
    axr(REG_ERR, d, r);
    chk("settle", d & 32'h2, 32'h2);
    // Clear and let settle run out so the next check sees only its flag
    axw(REG_ERR, 32'h7FF, r);
    i_ctrl.idle(8);
    i_ctrl.cmd(C_MS, 3'h0, 19'h00402);
    i_ctrl.idle(8);
    axr(REG_ERR, d, r);
    chk("upper", d & 32'h6, 32'h4);
    i_ctrl.cmd(C_REF, 3'h3, 19'h0);
    i_ctrl.cmd(C_REF, 3'h3, 19'h0);
    // Mode-set while bank 3 is still inside its row cycle
    i_ctrl.cmd(C_MS, 3'h0, 19'h2);
    i_ctrl.idle(2);
    axr(REG_ERR, d, r);
    chk("row", d & 32'h40, 32'h40);
    chk("busy", d & 32'h200, 32'h200);
    // A clear with no byte lane enabled must leave the flags alone
    wstrb <= 4'h0;
    axw(REG_ERR, 32'h7FF, r);
    wstrb <= 4'hF;
    axr(REG_ERR, d, r);
    chk("no lanes", d & 32'h240, 32'h240);
    axw(REG_ERR, 32'h7FF, r);
    i_ctrl.idle(8);
    i_ctrl.cmd(C_MS, 3'h0, 19'h4);
    i_ctrl.idle(8);
    i_ctrl.cmd(C_WR, 3'h1, 19'h0);
    i_ctrl.idle(3);
    i_ctrl.cmd(C_RD, 3'h1, 19'h0);
    i_ctrl.idle(2);
    axr(REG_ERR, d, r);
    chk("turn4", d & 32'h80, 32'h0);
    i_ctrl.cmd(C_WR, 3'h2, 19'h0);
    i_ctrl.idle(2);
    i_ctrl.cmd(C_RD, 3'h2, 19'h0);
    i_ctrl.idle(8);
    axr(REG_ERR, d, r);
    chk("turn3", d & 32'h80, 32'h80);
    axw(REG_ERR, 32'h7FF, r);
    i_ctrl.cmd(C_MS, 3'h0, 19'h00020);
    i_ctrl.idle(8);
    i_ctrl.cmd(C_MS, 3'h0, 19'h00229);
    i_ctrl.cmd(C_NOP, 3'h0, 19'h00210);
    i_ctrl.idle(8);
    chk("mux timing", tim(mode), 32'h70605);
    axr(REG_MODE, d, r);
    chk("mux mode", d, 32'h2AD);
    i_ctrl.cmd(C_REF, 3'h4, 19'h0);
    i_ctrl.cmd(C_REF, 3'h5, 19'h0);
    // Read long before the loop enabled by the mux mode-set has locked
    i_ctrl.cmd(C_RD, 3'h6, 19'h0);
    i_ctrl.idle(2);
    axr(REG_ERR, d, r);
    chk("mux refresh", d & 32'h46, 32'h0);
    chk("dll", d & 32'h100, 32'h100);
    axr(8'h14, d, r);
    chk("unmapped rd", {r, d[29:0]}, 32'h80000000);
    axw(8'h20, 32'h1, r);
    chk("unmapped wr", {30'h0, r}, 32'h2);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    chk("ready", {31'h0, init_ready}, 32'h0);
    axr(REG_MODE, d, r);
    chk("mode", d, 32'h0);
    i_ctrl.cmd(C_RD, 3'h0, 19'h0);
    i_ctrl.idle(2);
    axr(REG_ERR, d, r);
    chk("access", d & 32'h400, 32'h400);
    // With the enable off a mode-set on the pins must be ignored
    axw(REG_CTRL, 32'h0, r);
    i_ctrl.cmd(C_MS, 3'h0, 19'h3);
    i_ctrl.idle(8);
    axr(REG_TIMING, d, r);
    chk("disabled", d, 32'h50404);
    axw(REG_CTRL, 32'h3, r);
    axr(REG_CTRL, d, r);
    chk("ctrl", d, 32'h1);
    axr(REG_STATUS, d, r);
    chk("restart", d & 32'h1F, 32'h1);
    tally_and_finish();
  end
endmodule
